// *** hdl/cfc_consts.svh ***
// Purpose: offsets, field positions, reset values and scale constants
// Assumes: included by bare name from every design file that needs it
// Notes: currents are held in whole milliamps, voltages in millivolts
`ifndef CFC_CONSTS_SVH
`define CFC_CONSTS_SVH

// ---------------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------------
`define CFC_OFS_TS 8'h02
`define CFC_OFS_FC 8'h03

// ---------------------------------------------------------------------
// reset values (status bits of the temperature register read live)
// ---------------------------------------------------------------------
`define CFC_TS_RST 8'h88
`define CFC_FC_RST 8'h18

// ---------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------
`define CFC_THERMISTOR_SENSE_ENABLE_BIT 7
`define CFC_INT_SEL_BIT 3
`define CFC_WAKE_M_BIT 2
`define CFC_RESET_M_BIT 1
`define CFC_TIMER_M_BIT 0
`define CFC_RANGE_BIT 7
`define CFC_CE_BIT 1
`define CFC_HZ_BIT 0

// ---------------------------------------------------------------------
// temperature zone codes
// ---------------------------------------------------------------------
`define CFC_TZ_NORMAL 2'h0
`define CFC_TZ_COLD_HOT 2'h1
`define CFC_TZ_COOL 2'h2
`define CFC_TZ_WARM 2'h3

// ---------------------------------------------------------------------
// charge current scale, milliamps; resistor code; warm drop in millivolts
// ---------------------------------------------------------------------
`define CFC_LO_BASE 9'h005
`define CFC_LO_MAX 9'h023
`define CFC_HI_BASE 9'h028
`define CFC_HI_STEP 9'h00a
`define CFC_HI_MAX 9'h12c
`define CFC_EXT_CODE 4'hf
`define CFC_WARM_DROP_MV 8'h8c

// ---------------------------------------------------------------------
// serial target address (arbitrary value)
// ---------------------------------------------------------------------
`define CFC_DEV_ADDR 7'h35

`endif

// *** hdl/cfc_pkg.sv ***
// Purpose: shared types of the charger control registers
// Assumes: constants live in cfc_consts.svh
// Notes: state codes are one-hot
package cfc_pkg;

    // serial target byte engine states
    typedef enum logic [6:0] {
        CFC_IDLE  = 7'h01,
        CFC_ADDR  = 7'h02,
        CFC_ACK_A = 7'h04,
        CFC_WDATA = 7'h08,
        CFC_ACK_W = 7'h10,
        CFC_RDATA = 7'h20,
        CFC_ACK_R = 7'h40
    } cfc_i2c_st_e;

    // current in milliamps
    typedef logic [8:0] cfc_ma_t;

endpackage

// *** hdl/cfc_i2c_target.sv ***
// Purpose: byte-level serial target that moves register reads and writes
// Assumes: scl and sda already synchronous to clk_in
// Notes: first written byte sets the pointer, which auto-increments
`timescale 1ns/1ps
`include "cfc_consts.svh"
module cfc_i2c_target
    import cfc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // serial pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // register side
    output logic [7:0] reg_addr_out,
    output logic wr_en_out,
    output logic [7:0] wr_data_out,
    input wire logic [7:0] rd_data_in
);
    cfc_i2c_st_e st_q;
    logic scl_q, sda_q;      // previous pin levels
    logic [7:0] sh_q;        // shift register
    logic [3:0] cnt_q;       // bits seen in this byte
    logic rw_q;              // 1 when the host reads
    logic first_q;           // next written byte is the pointer
    logic rise, fall, start, stop;

    assign rise = scl_in & ~scl_q;
    assign fall = ~scl_in & scl_q;
    assign start = scl_in & scl_q & sda_q & ~sda_in;
    assign stop = scl_in & scl_q & ~sda_q & sda_in;

    // ---------------------------------------------------------------
    // pin history
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    // ---------------------------------------------------------------
    // byte engine
    // ---------------------------------------------------------------
    // start and stop win over bit activity so a broken frame resyncs
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_q <= CFC_IDLE;
            sh_q <= 8'h00;
            cnt_q <= 4'h0;
            rw_q <= 1'b0;
            first_q <= 1'b0;
            sda_oe_out <= 1'b0;
            reg_addr_out <= 8'h00;
            wr_en_out <= 1'b0;
            wr_data_out <= 8'h00;
        end else begin
            wr_en_out <= 1'b0;
            if (start) begin
                st_q <= CFC_ADDR;
                cnt_q <= 4'h0;
                first_q <= 1'b1;
                sda_oe_out <= 1'b0;
            end else if (stop) begin
                st_q <= CFC_IDLE;
                sda_oe_out <= 1'b0;
            end else begin
                case (st_q)
                    CFC_ADDR, CFC_WDATA: begin
                        if (rise) begin
                            sh_q <= {sh_q[6:0], sda_in};
                            cnt_q <= cnt_q + 4'h1;
                        end else if (fall && cnt_q == 4'h8) begin
                            cnt_q <= 4'h0;
                            if (st_q == CFC_ADDR) begin
                                // answer only our own address
                                if (sh_q[7:1] == `CFC_DEV_ADDR) begin
                                    rw_q <= sh_q[0];
                                    st_q <= CFC_ACK_A;
                                    sda_oe_out <= 1'b1;
                                end else begin
                                    st_q <= CFC_IDLE;
                                end
                            end else begin
                                st_q <= CFC_ACK_W;
                                sda_oe_out <= 1'b1;
                                if (first_q) begin
                                    reg_addr_out <= sh_q;
                                    first_q <= 1'b0;
                                end else begin
                                    wr_en_out <= 1'b1;
                                    wr_data_out <= sh_q;
                                end
                            end
                        end
                    end
                    CFC_ACK_A: begin
                        if (fall) begin
                            if (rw_q) begin
                                st_q <= CFC_RDATA;
                                sh_q <= rd_data_in;
                                sda_oe_out <= ~rd_data_in[7];
                            end else begin
                                st_q <= CFC_WDATA;
                                sda_oe_out <= 1'b0;
                            end
                        end
                    end
                    CFC_ACK_W: begin
                        // pointer moves the clock after a data strobe, so
                        // the write still lands on the old pointer; the
                        // pointer byte itself never moves it
                        if (wr_en_out) begin
                            reg_addr_out <= reg_addr_out + 8'h01;
                        end
                        if (fall) begin
                            st_q <= CFC_WDATA;
                            sda_oe_out <= 1'b0;
                        end
                    end
                    CFC_RDATA: begin
                        if (rise) begin
                            cnt_q <= cnt_q + 4'h1;
                        end else if (fall) begin
                            if (cnt_q == 4'h8) begin
                                st_q <= CFC_ACK_R;
                                sda_oe_out <= 1'b0;
                                reg_addr_out <= reg_addr_out + 8'h01;
                            end else begin
                                sh_q <= {sh_q[6:0], 1'b0};
                                sda_oe_out <= ~sh_q[6];
                            end
                        end
                    end
                    CFC_ACK_R: begin
                        // host nack ends the read burst
                        if (rise && sda_in) begin
                            st_q <= CFC_IDLE;
                        end else if (fall) begin
                            st_q <= CFC_RDATA;
                            cnt_q <= 4'h0;
                            sh_q <= rd_data_in;
                            sda_oe_out <= ~rd_data_in[7];
                        end
                    end
                    default: begin
                        st_q <= CFC_IDLE;
                    end
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // open-drain data pin only ever pulls low
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        sda_out <= 1'b0;
    end

endmodule

// *** hdl/cfc_charger_regs.sv ***
// Purpose: temperature control and fast-charge control registers
// Assumes: analog side reports the zone code and event pulses
// Notes: every output is registered, so settings follow a write by
//        one more clock
`timescale 1ns/1ps
`include "cfc_consts.svh"

// Summary of operation
// - bit 7 enables thermistor sensing
// - fault code 00 normal, 01 suspend, 10 cool
// - code 11 warm, regulation drops 140 mV
// - bit 3 adds charge status to interrupt
// - bit 2 masks push-button wake interrupt
// - bit 1 masks reset interrupt, not pin
// - bit 0 masks safety-timer fault interrupt
// - fast-charge register resets to 0x18, read/write
// - low range: 5 mA plus code mA
// - high range: 40 mA plus code times 10
// - code bits weigh 16..1 or 160..10 mA
// - over-range codes clamp to 35 or 300 mA
// - lower code bits all ones selects resistor
// - fast-charge bit 1 disables the charger
// - fast-charge bit 0 selects high impedance
// - resistor pin may override default current
// - temperature register resets to 1xx0 1000
module cfc_charger_regs
    import cfc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // serial pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // analog and event inputs
    input wire logic [1:0] temp_zone_in,
    input wire logic [8:0] ext_ma_in,
    input wire logic charge_set_resistor_pin_in,
    input wire logic fault_evt_in,
    input wire logic status_evt_in,
    input wire logic wake_evt_in,
    input wire logic pb_reset_evt_in,
    input wire logic timer_fault_evt_in,
    input wire logic pushbutton_input,
    // control outputs
    output logic thermistor_sense_enable_out,
    output logic current_halve_out,
    output logic charge_suspend_out,
    output logic [7:0] vreg_drop_mv_out,
    output logic [8:0] charge_ma_out,
    output logic ext_sel_out,
    output logic charger_disable_out,
    output logic high_z_select_out,
    output logic int_out,
    output logic reset_pin_out
);
    // ---------------------------------------------------------------
    // storage and bus signals
    // ---------------------------------------------------------------
    logic [7:0] ts_q;        // only bits 7 and 3..0 are stored
    logic [7:0] fc_q;        // fast-charge control, all bits stored
    logic [7:0] reg_addr;    // pointer from the serial target
    logic wr_en;             // one-cycle write strobe
    logic [7:0] wr_data;     // written byte
    logic [7:0] rd_data;     // read mux into the serial target
    logic [1:0] zone;        // zone code seen by software
    logic ext_sel;           // resistor current in use
    cfc_ma_t reg_ma;         // current from the register code
    logic [4:0] code;        // five-bit charge code

    assign code = fc_q[6:2];

    // ---------------------------------------------------------------
    // serial target
    // ---------------------------------------------------------------
    cfc_i2c_target u_i2c (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe_out(sda_oe_out),
        .reg_addr_out(reg_addr),
        .wr_en_out(wr_en),
        .wr_data_out(wr_data),
        .rd_data_in(rd_data)
    );

    // ---------------------------------------------------------------
    // current from range and code
    // ---------------------------------------------------------------
    // the sum is built at 9 bits so 40 + 31*10 never wraps
    function automatic cfc_ma_t calc_ma(input logic hi,
                                        input logic [4:0] c);
        cfc_ma_t w;
        w = {4'h0, c};
        if (hi) begin
            w = `CFC_HI_BASE + w * `CFC_HI_STEP;
            if (w > `CFC_HI_MAX) begin
                w = `CFC_HI_MAX;
            end
        end else begin
            w = `CFC_LO_BASE + w;
            if (w > `CFC_LO_MAX) begin
                w = `CFC_LO_MAX;
            end
        end
        return w;
    endfunction

    // ---------------------------------------------------------------
    // temperature control register
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ts_q <= `CFC_TS_RST;
        end else if (wr_en && reg_addr == `CFC_OFS_TS) begin
            ts_q <= {wr_data[7], 3'h0, wr_data[3:0]};
        end
    end

    // ---------------------------------------------------------------
    // fast-charge control register
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            fc_q <= `CFC_FC_RST;
        end else if (wr_en && reg_addr == `CFC_OFS_FC) begin
            fc_q <= wr_data;
        end
    end

    // ---------------------------------------------------------------
    // read mux
    // ---------------------------------------------------------------
    // with sensing off no zone is judged, so the code reads normal
    always_comb begin
        zone = ts_q[`CFC_THERMISTOR_SENSE_ENABLE_BIT] ? temp_zone_in : `CFC_TZ_NORMAL;
        case (reg_addr)
            `CFC_OFS_TS: rd_data = {ts_q[7], zone, 1'b0, ts_q[3:0]};
            `CFC_OFS_FC: rd_data = fc_q;
            default: rd_data = 8'h00;
        endcase
    end

    // ---------------------------------------------------------------
    // current selection
    // ---------------------------------------------------------------
    always_comb begin
        reg_ma = calc_ma(fc_q[`CFC_RANGE_BIT], code);
        ext_sel = (code[3:0] == `CFC_EXT_CODE) ||
                  (charge_set_resistor_pin_in && fc_q == `CFC_FC_RST);
    end

    // ---------------------------------------------------------------
    // charge outputs
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            charge_ma_out <= 9'h000;
            ext_sel_out <= 1'b0;
            charger_disable_out <= 1'b0;
            high_z_select_out <= 1'b0;
        end else begin
            ext_sel_out <= ext_sel;
            charge_ma_out <= ext_sel ? ext_ma_in : reg_ma;
            charger_disable_out <= fc_q[`CFC_CE_BIT];
            high_z_select_out <= fc_q[`CFC_HZ_BIT];
        end
    end

    // ---------------------------------------------------------------
    // temperature outputs
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            thermistor_sense_enable_out <= 1'b1;
            current_halve_out <= 1'b0;
            charge_suspend_out <= 1'b0;
            vreg_drop_mv_out <= 8'h00;
        end else begin
            thermistor_sense_enable_out <= ts_q[`CFC_THERMISTOR_SENSE_ENABLE_BIT];
            charge_suspend_out <= (zone == `CFC_TZ_COLD_HOT);
            current_halve_out <= (zone == `CFC_TZ_COOL);
            vreg_drop_mv_out <= (zone == `CFC_TZ_WARM) ?
                                `CFC_WARM_DROP_MV : 8'h00;
        end
    end

    // ---------------------------------------------------------------
    // interrupt and reset pin
    // ---------------------------------------------------------------
    // events are pulses; int_out is a one-cycle pulse per enabled event, reset_pin_out also stays high while the push-button is held
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            int_out <= 1'b0;
            reset_pin_out <= 1'b0;
        end else begin
            int_out <= fault_evt_in |
                (ts_q[`CFC_INT_SEL_BIT] & status_evt_in) |
                (~ts_q[`CFC_WAKE_M_BIT] & wake_evt_in) |
                (~ts_q[`CFC_RESET_M_BIT] & pb_reset_evt_in) |
                (~ts_q[`CFC_TIMER_M_BIT] & timer_fault_evt_in);
            reset_pin_out <= pb_reset_evt_in | ~pushbutton_input;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence s_fc_write;
        wr_en && reg_addr == `CFC_OFS_FC;
    endsequence

    sequence s_fc_settle;
        fc_q == $past(wr_data) ##1
        charger_disable_out == $past(wr_data[1], 2);
    endsequence

    property p_ts_reset;
        @(posedge clk_in) rst_in |=> ts_q == `CFC_TS_RST;
    endproperty
    a_ts_reset: assert property (p_ts_reset)
        else $error("temperature register reset value wrong");

    property p_fc_reset;
        @(posedge clk_in) rst_in ##1 !rst_in |=>
            ext_sel_out == $past(charge_set_resistor_pin_in) &&
            charge_ma_out == (ext_sel_out ? $past(ext_ma_in) : 9'h00b) &&
            !charger_disable_out;
    endproperty
    a_fc_reset: assert property (p_fc_reset)
        else $error("fast-charge reset setting wrong");

    property p_fc_write;
        @(posedge clk_in) disable iff (rst_in)
            s_fc_write |=> s_fc_settle;
    endproperty
    a_fc_write: assert property (p_fc_write)
        else $error("fast-charge write did not take effect");

    property p_ro_bits;
        @(posedge clk_in) disable iff (rst_in)
            wr_en && reg_addr == `CFC_OFS_TS |=>
            ts_q == {$past(wr_data[7]), 3'h0, $past(wr_data[3:0])};
    endproperty
    a_ro_bits: assert property (p_ro_bits)
        else $error("read-only bits took a write");

    property p_lo_range;
        @(posedge clk_in) disable iff (rst_in)
            !fc_q[7] && !ext_sel && code != 5'h1f |=>
            charge_ma_out == 9'h005 + {4'h0, $past(code)};
    endproperty
    a_lo_range: assert property (p_lo_range)
        else $error("low range current wrong");

    property p_hi_clamp;
        @(posedge clk_in) disable iff (rst_in)
            fc_q[7] && !ext_sel && code > 5'h1a |=>
            charge_ma_out == 9'h12c;
    endproperty
    a_hi_clamp: assert property (p_hi_clamp)
        else $error("high range clamp missing");

    property p_hi_range;
        @(posedge clk_in) disable iff (rst_in)
            fc_q[7] && !ext_sel && code < 5'h1b |=>
            charge_ma_out == 9'h028 + 9'h00a * {4'h0, $past(code)};
    endproperty
    a_hi_range: assert property (p_hi_range)
        else $error("high range current wrong");

    property p_ext;
        @(posedge clk_in) disable iff (rst_in)
            code[3:0] == 4'hf |=>
            ext_sel_out && charge_ma_out == $past(ext_ma_in);
    endproperty
    a_ext: assert property (p_ext)
        else $error("resistor current not selected");

    property p_timer_mask;
        @(posedge clk_in) disable iff (rst_in)
            timer_fault_evt_in && ts_q[0] && !fault_evt_in &&
            !status_evt_in && !wake_evt_in && !pb_reset_evt_in
            |=> !int_out;
    endproperty
    a_timer_mask: assert property (p_timer_mask)
        else $error("masked timer fault raised interrupt");

    property p_reset_pin;
        @(posedge clk_in) disable iff (rst_in)
            pb_reset_evt_in && ts_q[1] |=> reset_pin_out;
    endproperty
    a_reset_pin: assert property (p_reset_pin)
        else $error("reset pin blocked by mask");

endmodule

// *** tb/cfc_host_model.sv ***
// Purpose: serial host model driving the register target
// Assumes: open-drain data line with pull-up, resolved by the bench
// Notes: every scl phase lasts four clocks
`timescale 1ns/1ps
`include "cfc_consts.svh"
module cfc_host_model (
    // clock
    input wire logic clk_in,
    // serial wire
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low_out
);
    logic [7:0] rd_q; // shifted-in line samples
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    // one phase; four clocks keeps clear of the three-clock minimum
    task automatic ph();
        repeat (4) @(negedge clk_in);
    endtask
    // data moves only while scl is low, sampled at end of high phase
    task automatic bit_io(input logic b);
        sda_low_out = ~b;
        ph();
        scl_out = 1'b1;
        ph();
        rd_q = {rd_q[6:0], sda_in};
        scl_out = 1'b0;
        ph();
    endtask
    // start or repeated start
    task automatic start();
        sda_low_out = 1'b0;
        ph();
        scl_out = 1'b1;
        ph();
        sda_low_out = 1'b1;
        ph();
        scl_out = 1'b0;
        ph();
    endtask
    task automatic stop();
        sda_low_out = 1'b1;
        ph();
        scl_out = 1'b1;
        ph();
        sda_low_out = 1'b0;
        ph();
    endtask
    // byte out msb first, then release for the target ack
    task automatic wbyte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i]);
        end
        bit_io(1'b1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        start();
        wbyte({`CFC_DEV_ADDR, 1'b0});
        wbyte(a);
        wbyte(d);
        stop();
    endtask
    // pointer write, repeated start, one byte, nack
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        start();
        wbyte({`CFC_DEV_ADDR, 1'b0});
        wbyte(a);
        start();
        wbyte({`CFC_DEV_ADDR, 1'b1});
        repeat (8) bit_io(1'b1);
        d = rd_q;
        bit_io(1'b1);
        stop();
    endtask
endmodule

// *** tb/test_charger_ts_and_fastcharge_regs.sv ***
// Purpose: register and control-output test of the charger block
// Assumes: host model speaks the serial target protocol
// Notes: resistor current is fixed at 200 mA
`timescale 1ns/1ps
module test_charger_ts_and_fastcharge_regs
    import cfc_pkg::*;
;
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    bad_count++; $display("BAD %s exp %h got %h", nm, e, g); end end
    logic clk_in, rst_in, scl, host_low, sda_out, sda_oe, res_pin, pb_n;
    logic tse, halve, susp, ext_sel, dis, hz, intr, rpin;
    logic [1:0] zone;
    logic [4:0] evt; // timer, pb reset, wake, status, fault
    logic [7:0] drop, rd_v;
    cfc_ma_t ma;
    int bad_count, n_checks, cyc;
    // open drain: low when either side pulls
    wire sda = ~((sda_oe & ~sda_out) | host_low);
    localparam logic [7:0] FCV [8] = '{8'h04, 8'h40, 8'h78, 8'he8,
        8'hec, 8'h7c, 8'h9f, 8'h02};
    localparam cfc_ma_t FCE [8] = '{9'h006, 9'h015, 9'h023, 9'h12c,
        9'h12c, 9'h0c8, 9'h06e, 9'h005};
    cfc_host_model u_cfc_host_model (.clk_in(clk_in), .sda_in(sda),
        .scl_out(scl), .sda_low_out(host_low));
    cfc_charger_regs u_cfc_charger_regs (.clk_in(clk_in),
        .rst_in(rst_in), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe_out(sda_oe), .temp_zone_in(zone), .ext_ma_in(9'h0c8),
        .charge_set_resistor_pin_in(res_pin), .fault_evt_in(evt[0]),
        .status_evt_in(evt[1]), .wake_evt_in(evt[2]),
        .pb_reset_evt_in(evt[3]), .timer_fault_evt_in(evt[4]),
        .pushbutton_input(pb_n), .thermistor_sense_enable_out(tse),
        .current_halve_out(halve), .charge_suspend_out(susp),
        .vreg_drop_mv_out(drop), .charge_ma_out(ma),
        .ext_sel_out(ext_sel), .charger_disable_out(dis),
        .high_z_select_out(hz), .int_out(intr), .reset_pin_out(rpin));
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    task automatic report_and_stop();
        if (bad_count == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // a hang counts as a mismatch
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            report_and_stop();
        end
    end
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        u_cfc_host_model.rd(a, rd_v);
        `CHK("reg", e, rd_v)
    endtask
    // one-cycle event, then watch int and reset pin for three cycles
    task automatic pulse(input int k, input logic ei, input logic er);
        logic hi, hr;
        hi = 1'b0;
        hr = 1'b0;
        evt[k] = 1'b1;
        repeat (3) begin
            @(negedge clk_in);
            evt[k] = 1'b0;
            hi = hi | intr;
            hr = hr | rpin;
        end
        `CHK("int", ei, hi)
        `CHK("rpin", er, hr)
    endtask
    initial begin
        rst_in = 1'b1;
        res_pin = 1'b0;
        pb_n = 1'b1;
        zone = 2'h0;
        evt = 5'h00;
        repeat (4) @(negedge clk_in);
        rst_in = 1'b0;
        repeat (2) @(negedge clk_in);
        `CHK("tse", 1'b1, tse)
        `CHK("ma", 9'h00b, ma)
        chk_rd(8'h02, 8'h88);
        chk_rd(8'h03, 8'h18);
        for (int z = 0; z < 4; z++) begin
            zone = z[1:0];
            repeat (3) @(negedge clk_in);
            chk_rd(8'h02, {1'b1, z[1:0], 5'h08});
            `CHK("susp", z == 1, susp)
            `CHK("halve", z == 2, halve)
            `CHK("drop", (z == 3) ? 8'h8c : 8'h00, drop)
        end
        u_cfc_host_model.wr(8'h02, 8'h7f);
        chk_rd(8'h02, 8'h0f);
        `CHK("tse", 1'b0, tse)
        pulse(2, 1'b0, 1'b0);
        pulse(3, 1'b0, 1'b1);
        pulse(4, 1'b0, 1'b0);
        pulse(1, 1'b1, 1'b0);
        u_cfc_host_model.wr(8'h02, 8'h80);
        pulse(1, 1'b0, 1'b0);
        pulse(0, 1'b1, 1'b0);
        pulse(2, 1'b1, 1'b0);
        pulse(3, 1'b1, 1'b1);
        pulse(4, 1'b1, 1'b0);
        // held push-button drives the reset pin with no event
        pb_n = 1'b0;
        repeat (2) @(negedge clk_in);
        `CHK("rpin", 1'b1, rpin)
        pb_n = 1'b1;
        repeat (2) @(negedge clk_in);
        `CHK("rpin", 1'b0, rpin)
        u_cfc_host_model.wr(8'h04, 8'h04);
        chk_rd(8'h04, 8'h00);
        for (int i = 0; i < 8; i++) begin
            u_cfc_host_model.wr(8'h03, FCV[i]);
            repeat (3) @(negedge clk_in);
            chk_rd(8'h03, FCV[i]);
            `CHK("ma", FCE[i], ma)
            `CHK("ext", FCV[i][5:2] == 4'hf, ext_sel)
            `CHK("dis", FCV[i][1], dis)
            `CHK("hz", FCV[i][0], hz)
        end
        // second reset with the set resistor fitted
        res_pin = 1'b1;
        rst_in = 1'b1;
        repeat (4) @(negedge clk_in);
        rst_in = 1'b0;
        repeat (3) @(negedge clk_in);
        `CHK("ma", 9'h0c8, ma)
        `CHK("ext", 1'b1, ext_sel)
        report_and_stop();
    end
endmodule
